// [adc_sequencer_model.sv]
// behavioural model of the adc sequencer that answers auto-monitor starts
module adc_sequencer_model #(
	parameter int RUN_CYCLES = 20 // length of one auto-monitor run
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic start_i, // start pulse from the register group
	output logic busy_o, // conversion in progress
	output logic done_o // one-cycle pulse at end of run
);
	int cnt_q;
	// a start seen while running is dropped, never queued
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 0;
		end else if (start_i && cnt_q == 0) begin
			cnt_q <= RUN_CYCLES;
		end else if (cnt_q != 0) begin
			cnt_q <= cnt_q - 1;
		end
	end
	// busy for the whole run, done in its last cycle
	assign busy_o = cnt_q != 0;
	assign done_o = cnt_q == 1;
endmodule

// [monitor_status_pkg.sv]
// package: register map, field positions and reset values of the monitor status register group
package monitor_status_pkg;
	// register offsets are word indices: byte address = 4 * index
	localparam logic [7:0] IDX_TEST_SAMPLE_INTERVALS = 8'h43;
	localparam logic [7:0] IDX_SHUTDOWN_CAUSE = 8'h50;
	localparam logic [7:0] IDX_DEVICE_STATE = 8'h51;
	localparam logic [7:0] IDX_DEVICE_CONFIG = 8'h60; // fault-high enable, auto-monitor period
	localparam int ADDR_W = 10;
	// test_sample_intervals fields
	localparam int MOD_CODE_LSB = 12;
	localparam int REF_CODE_LSB = 4;
	localparam int SUPPLY_CODE_LSB = 0;
	localparam int RSVD_LSB = 8;
	localparam logic [3:0] RSVD_PATTERN = 4'h9;
	localparam logic [15:0] TEST_SAMPLE_RESET = 16'h0900;
	// device_state bit positions
	localparam int ST_FAULT = 7;
	localparam int ST_CHAIN_LIVE = 6;
	localparam int ST_CHAIN_LATCHED = 5;
	localparam int ST_LINK_CLEAR = 4;
	localparam int ST_LINK_RESET = 3;
	localparam int ST_AUTO_RUN = 2;
	localparam int ST_NEW_DATA = 1;
	localparam int ST_INIT = 0;
	// device_config fields
	localparam int CFG_FAULT_HIGH_EN = 8;
	localparam logic [8:0] DEVICE_CONFIG_RESET = 9'h000;
	// sampling interval table, hundredths of a microsecond per code
	localparam int CLK_MHZ = 25;
	localparam int INTERVAL_SCALE = 100; // table steps per microsecond
	localparam int INTERVAL_HUNDREDTHS_US [16] = '{413, 596, 802, 1000, 1260, 1490, 1740,
		1990, 2490, 3000, 4010, 6000, 10000, 20000, 50000, 100000};
	localparam int CNT_W = 15;
	// shutdown cause inputs, one bit each
	typedef struct packed {
		logic logic_powerdown;
		logic digital_thermal;
		logic supply_loss;
		logic analog_die;
		logic regulator_slow;
		logic analog_thermal;
	} shutdown_evt_t;
	// auto-monitor sequencer states
	typedef enum logic [1:0] {
		AM_IDLE = 2'b01,
		AM_RUN = 2'b10
	} am_state_t;
endpackage

// [monitor_status_regs.sv]
// monitor status / shutdown cause / test sampling interval register group, wishbone slave
//
// Register access over Wishbone was decided locally.
module monitor_status_regs
	import monitor_status_pkg::*;
#(
	parameter int PERIOD_W = 8 // width of the auto-monitor period field
) (
	input wire logic clk_i, // 25 MHz clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic cyc_i, // wishbone cycle
	input wire logic stb_i, // wishbone strobe
	input wire logic we_i, // wishbone write enable
	input wire logic [ADDR_W-1:0] adr_i, // wishbone byte address
	input wire logic [3:0] sel_i, // wishbone byte selects
	input wire logic [31:0] dat_i, // wishbone write data
	output logic [31:0] dat_o, // wishbone read data
	output logic ack_o, // wishbone acknowledge
	input wire logic fault_summary_i, // any bit set in the fault registers
	input wire logic chain_fault_i, // differential stack fault input (pin)
	input wire logic link_clear_i, // one-cycle pulse: link clear detected
	input wire logic link_reset_i, // one-cycle pulse: link reset detected
	input wire shutdown_evt_t shutdown_evt_i, // one-cycle shutdown cause pulses
	input wire logic sample_done_i, // one-cycle pulse: conversion data collected
	input wire logic sample_internal_i, // that sample was temperature or init sampling
	input wire logic result_read_i, // one-cycle pulse: a conversion result was read
	input wire logic conversion_busy_i, // auto-monitor adc conversion in progress
	input wire logic conversion_done_i, // one-cycle pulse: auto-monitor cycle finished
	input wire logic supply_ok_i, // module supply in range
	output logic auto_start_o, // one-cycle pulse: start auto-monitor cycle
	output logic supply_wait_skip_o, // stop waiting for module supply
	output logic [3:0] module_interval_code_o, // module monitor interval code
	output logic [3:0] ref_interval_code_o, // analog reference interval code
	output logic [3:0] supply_monitor_interval_code_o, // supply monitor interval code
	output logic [CNT_W-1:0] module_interval_cycles_o, // module interval in clock cycles
	output logic [CNT_W-1:0] ref_interval_cycles_o, // reference interval in clock cycles
	output logic [CNT_W-1:0] supply_interval_cycles_o, // supply interval in clock cycles
	output logic fault_o // device fault output, active high
);
	// interval lookup: hundredths of a microsecond times MHz over 100, rounded down, at least one cycle
	function automatic logic [CNT_W-1:0] interval_cycles(input logic [3:0] code);
		int c;
		c = (INTERVAL_HUNDREDTHS_US[code] * CLK_MHZ) / INTERVAL_SCALE;
		if (c < 1) begin
			c = 1;
		end
		return CNT_W'(c);
	endfunction

	logic [15:0] test_sample_q;
	logic [5:0] shdn_q; // {7,6,5,4,1,0}
	logic chain_latched_q;
	logic link_clear_q;
	logic link_reset_q;
	logic new_data_q;
	logic init_q;
	logic skip_q;
	logic fault_high_en_q;
	logic [PERIOD_W-1:0] am_period_q;
	am_state_t am_q;
	logic [2:0] chain_sync_q;
	logic chain_live_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic [7:0] idx;
	logic req;
	logic wr;
	logic rd;
	logic hit_test;
	logic hit_shdn;
	logic hit_state;
	logic hit_cfg;
	logic [7:0] shdn_view;
	logic [7:0] state_view;
	logic chain_masked;
	logic start_req;

	// bus decode: one access answered one cycle after the request
	assign idx = adr_i[ADDR_W-1:2];
	assign req = cyc_i && stb_i && !ack_q;
	assign wr = req && we_i;
	assign rd = req && !we_i;
	assign hit_test = idx == IDX_TEST_SAMPLE_INTERVALS;
	assign hit_shdn = idx == IDX_SHUTDOWN_CAUSE;
	assign hit_state = idx == IDX_DEVICE_STATE;
	assign hit_cfg = idx == IDX_DEVICE_CONFIG;
	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// acknowledge every addressed request, mapped or not
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// read data register; unmapped indices read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
		end else if (rd) begin
			if (hit_test) begin
				dat_q <= {16'h0000, test_sample_q};
			end else if (hit_shdn) begin
				dat_q <= {24'h00_0000, shdn_view};
			end else if (hit_state) begin
				dat_q <= {24'h00_0000, state_view};
			end else if (hit_cfg) begin
				dat_q <= {23'h00_0000, fault_high_en_q, am_period_q};
			end else begin
				dat_q <= 32'h0000_0000;
			end
		end
	end

	// test interval register, byte lanes honoured; bits 11:8 stored as written
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			test_sample_q <= TEST_SAMPLE_RESET;
		end else if (wr && hit_test) begin
			if (sel_i[0]) begin
				test_sample_q[7:0] <= dat_i[7:0];
			end
			if (sel_i[1]) begin
				test_sample_q[15:8] <= dat_i[15:8];
			end
		end
	end

	// interval code fields and their cycle counts
	assign module_interval_code_o = test_sample_q[MOD_CODE_LSB +: 4];
	assign ref_interval_code_o = test_sample_q[REF_CODE_LSB +: 4];
	assign supply_monitor_interval_code_o = test_sample_q[SUPPLY_CODE_LSB +: 4];
	assign module_interval_cycles_o = interval_cycles(module_interval_code_o);
	assign ref_interval_cycles_o = interval_cycles(ref_interval_code_o);
	assign supply_interval_cycles_o = interval_cycles(supply_monitor_interval_code_o);

	// config register: fault-high enable and auto-monitor period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_high_en_q <= DEVICE_CONFIG_RESET[CFG_FAULT_HIGH_EN];
			am_period_q <= PERIOD_W'(0);
		end else if (wr && hit_cfg) begin
			if (sel_i[0]) begin
				am_period_q <= dat_i[PERIOD_W-1:0];
			end
			if (sel_i[1]) begin
				fault_high_en_q <= dat_i[CFG_FAULT_HIGH_EN];
			end
		end
	end

	// shutdown cause flags: sticky, set by events, cleared only by reset (read-only)
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shdn_q <= 6'h00;
		end else begin
			if (shutdown_evt_i.logic_powerdown) shdn_q[5] <= 1'b1;
			if (shutdown_evt_i.digital_thermal) shdn_q[4] <= 1'b1;
			if (shutdown_evt_i.supply_loss) shdn_q[3] <= 1'b1;
			if (shutdown_evt_i.analog_die) shdn_q[2] <= 1'b1;
			if (shutdown_evt_i.regulator_slow) shdn_q[1] <= 1'b1;
			if (shutdown_evt_i.analog_thermal) shdn_q[0] <= 1'b1;
		end
	end
	assign shdn_view = {shdn_q[5:2], 2'b00, shdn_q[1:0]};

	// chain fault pin: three flops, change accepted when second and third agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chain_sync_q <= 3'b000;
			chain_live_q <= 1'b0;
		end else begin
			chain_sync_q <= {chain_sync_q[1:0], chain_fault_i};
			if (chain_sync_q[1] == chain_sync_q[2]) begin
				chain_live_q <= chain_sync_q[2];
			end
		end
	end
	assign chain_masked = chain_live_q && fault_high_en_q;

	// write-one-to-clear flags; a set in the same cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chain_latched_q <= 1'b0;
			link_clear_q <= 1'b0;
			link_reset_q <= 1'b0;
		end else begin
			if (chain_masked) begin
				chain_latched_q <= 1'b1;
			end else if (wr && hit_state && sel_i[0] && dat_i[ST_CHAIN_LATCHED]) begin
				chain_latched_q <= 1'b0;
			end
			if (link_clear_i) begin
				link_clear_q <= 1'b1;
			end else if (wr && hit_state && sel_i[0] && dat_i[ST_LINK_CLEAR]) begin
				link_clear_q <= 1'b0;
			end
			if (link_reset_i) begin
				link_reset_q <= 1'b1;
			end else if (wr && hit_state && sel_i[0] && dat_i[ST_LINK_RESET]) begin
				link_reset_q <= 1'b0;
			end
		end
	end

	// new-data flag: set by real samples only, cleared by a result read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			new_data_q <= 1'b0;
		end else if (sample_done_i && !sample_internal_i) begin
			new_data_q <= 1'b1;
		end else if (result_read_i) begin
			new_data_q <= 1'b0;
		end
	end

	// init flag: set from reset until supply is good or software skips the wait
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			init_q <= 1'b1;
			skip_q <= 1'b0;
		end else begin
			if (wr && hit_state && sel_i[0] && dat_i[ST_INIT] && init_q) begin
				skip_q <= 1'b1;
			end
			if (supply_ok_i || skip_q) begin
				init_q <= 1'b0;
			end
		end
	end
	assign supply_wait_skip_o = skip_q;

	// auto-monitor: start only from idle with a non-zero period
	assign start_req = wr && hit_state && sel_i[0] && dat_i[ST_AUTO_RUN];
	// a busy converter also counts as running, so a start never overlaps a conversion
	assign auto_start_o = start_req && (am_q == AM_IDLE) && !conversion_busy_i
		&& (am_period_q != '0);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			am_q <= AM_IDLE;
		end else begin
			case (am_q)
				AM_IDLE: begin
					if (auto_start_o) begin
						am_q <= AM_RUN;
					end
				end
				AM_RUN: begin
					if (conversion_done_i) begin
						am_q <= AM_IDLE;
					end
				end
				default: begin
					am_q <= AM_IDLE;
				end
			endcase
		end
	end

	// status view; bits 7 and 6 are live and ignore writes
	assign state_view = {fault_summary_i, chain_masked, chain_latched_q && fault_high_en_q,
		link_clear_q, link_reset_q, (am_q == AM_RUN) || conversion_busy_i, new_data_q,
		init_q};

	// fault output: summary or live chain fault; latched and link flags stay out
	assign fault_o = fault_summary_i || chain_masked;

	// checks
	AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
		else $error("ack not one cycle after request");
	AST_FAULT_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
		fault_o == (state_view[ST_FAULT] || state_view[ST_CHAIN_LIVE]))
		else $error("fault output mismatch");
	AST_SUMMARY: assert property (@(posedge clk_i) disable iff (rst_i)
		state_view[ST_FAULT] == fault_summary_i)
		else $error("status fault bit does not follow summary");
	AST_SHDN_RSVD: assert property (@(posedge clk_i) disable iff (rst_i)
		(ack_o && $past(rd && hit_shdn))
		|-> (dat_o[3:2] == 2'b00) && (dat_o[31:8] == 24'h00_0000))
		else $error("reserved shutdown bits not zero");
	AST_POWERDOWN: assert property (@(posedge clk_i) disable iff (rst_i)
		shutdown_evt_i.logic_powerdown |=> shdn_view[7] [*3])
		else $error("logic power-down flag not sticky");
	AST_THERMAL: assert property (@(posedge clk_i) disable iff (rst_i)
		shutdown_evt_i.digital_thermal |=> shdn_view[6])
		else $error("digital thermal flag not set");
	AST_SUPPLY: assert property (@(posedge clk_i) disable iff (rst_i)
		shutdown_evt_i.supply_loss |=> shdn_view[5])
		else $error("supply loss flag not set");
	AST_ANALOG: assert property (@(posedge clk_i) disable iff (rst_i)
		shutdown_evt_i.analog_die |=> shdn_view[4])
		else $error("analog die flag not set");
	AST_ANALOG_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
		shutdown_evt_i.regulator_slow |=> shdn_view[1])
		else $error("regulator slow flag not set");
	AST_HOT_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
		shutdown_evt_i.analog_thermal |=> shdn_view[0])
		else $error("analog thermal flag not set");
	AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		chain_masked |=> chain_latched_q)
		else $error("chain fault not latched");
	AST_LATCH_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
		(!chain_masked && wr && hit_state && sel_i[0] && dat_i[ST_CHAIN_LATCHED])
		|=> !chain_latched_q)
		else $error("latched chain fault not cleared");
	AST_CHAIN_LIVE: assert property (@(posedge clk_i) disable iff (rst_i)
		(fault_high_en_q && !(wr && hit_cfg) && chain_sync_q[2] && chain_sync_q[1])
		|=> state_view[ST_CHAIN_LIVE])
		else $error("live chain fault not shown");
	AST_LINK_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
		(link_clear_q && !link_clear_i && wr && hit_state && sel_i[0]
		&& dat_i[ST_LINK_CLEAR]) |=> !link_clear_q)
		else $error("link clear flag not cleared");
	AST_LINK_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		link_clear_i |=> link_clear_q)
		else $error("link clear flag not set");
	AST_LINK_RST: assert property (@(posedge clk_i) disable iff (rst_i)
		link_reset_i |=> link_reset_q)
		else $error("link reset flag not set");
	AST_LINK_RST_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
		(!link_reset_i && wr && hit_state && sel_i[0] && dat_i[ST_LINK_RESET])
		|=> !link_reset_q)
		else $error("link reset flag not cleared");
	AST_NO_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
		(start_req && state_view[ST_AUTO_RUN]) |-> !auto_start_o)
		else $error("auto-monitor restarted while running");
	AST_START: assert property (@(posedge clk_i) disable iff (rst_i)
		auto_start_o |=> state_view[ST_AUTO_RUN])
		else $error("auto-monitor not running after start");
	AST_NEW_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
		(sample_done_i && sample_internal_i && !new_data_q) |=> !new_data_q)
		else $error("internal sample set new-data flag");
	AST_NEW_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		(sample_done_i && !sample_internal_i) |=> new_data_q)
		else $error("new-data flag not set");
	AST_NEW_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
		(result_read_i && !sample_done_i) |=> !new_data_q)
		else $error("new-data flag not cleared by result read");
	AST_NEW_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && hit_state && !sample_done_i && !result_read_i) |=> $stable(new_data_q))
		else $error("status write changed new-data flag");
	AST_INIT: assert property (@(posedge clk_i) disable iff (rst_i)
		(init_q && supply_ok_i) |=> !init_q)
		else $error("init flag stayed set with supply good");
	AST_SKIP: assert property (@(posedge clk_i) disable iff (rst_i)
		(init_q && wr && hit_state && sel_i[0] && dat_i[ST_INIT]) |=> ##1 !init_q)
		else $error("init flag stayed set after skip");
	AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i)
		(ack_o && $past(rd && !(hit_test || hit_shdn || hit_state || hit_cfg)))
		|-> (dat_o == 32'h0000_0000))
		else $error("unmapped read not zero");
	AST_TEST_READ: assert property (@(posedge clk_i) disable iff (rst_i)
		(ack_o && $past(rd && hit_test)) |-> (dat_o == {16'h0000, $past(test_sample_q)}))
		else $error("test interval read data wrong");
endmodule

// [tb_monitor_status_regs.sv]
// self-checking testbench of the monitor status register group
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
	$display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module tb_monitor_status_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import monitor_status_pkg::*;
	logic clk_i = 0;
	logic rst_i = 1;
	logic req = 0;
	logic we = 0;
	logic [9:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic ack_o;
	logic summ = 0;
	logic chain = 0;
	logic s_int = 0;
	logic sok = 0;
	logic [9:0] pv = '0;
	logic busy, done, start, skip, fault_o;
	logic [3:0] mc, rc, vc;
	logic [CNT_W-1:0] mcy, rcy, vcy;
	logic [15:0] v;
	logic [7:0] exp_sd = '0;
	int cpos[6] = '{0, 1, 4, 5, 6, 7};
	int err_total = 0;
	int n_tests = 0;
	int n_start = 0;
	monitor_status_regs monitor_status_regs_inst (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
		.dat_o(dat_o), .ack_o(ack_o), .fault_summary_i(summ), .chain_fault_i(chain),
		.link_clear_i(pv[6]), .link_reset_i(pv[7]),
		.shutdown_evt_i(shutdown_evt_t'(pv[5:0])), .sample_done_i(pv[8]),
		.sample_internal_i(s_int), .result_read_i(pv[9]), .conversion_busy_i(busy),
		.conversion_done_i(done), .supply_ok_i(sok), .auto_start_o(start),
		.supply_wait_skip_o(skip), .module_interval_code_o(mc), .ref_interval_code_o(rc),
		.supply_monitor_interval_code_o(vc), .module_interval_cycles_o(mcy),
		.ref_interval_cycles_o(rcy), .supply_interval_cycles_o(vcy), .fault_o(fault_o));
	adc_sequencer_model adc_sequencer_model_inst (.clk_i(clk_i), .rst_i(rst_i),
		.start_i(start), .busy_o(busy), .done_o(done));
	// clock
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// counts start pulses handed to the sequencer
	always @(posedge clk_i) begin
		if (start === 1'b1) n_start <= n_start + 1;
	end
	task end_sim;
		if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// one classic cycle, held until ack is seen, then idle for a cycle
	task wb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
		int n;
		req <= 1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= d;
		sel <= s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) begin
			err_total++;
			end_sim();
		end
		rd = dat_o;
		req <= 0;
		we <= 0;
		@(posedge clk_i);
	endtask
	task rdchk(input logic [7:0] idx, input logic [31:0] e);
		wb(0, idx, 32'h0, 4'hf);
		`CHK(rd, e)
	endtask
	task pulse(input int k);
		pv <= 10'(1) << k;
		@(posedge clk_i);
		pv <= '0;
		@(posedge clk_i);
	endtask
	// expected interval in 40 ns cycles, rounded down, per code
	int ecy_tab[16] = '{103, 149, 200, 250, 315, 372, 435, 497, 622, 750, 1002, 1500, 2500,
		5000, 12500, 25000};
	function automatic logic [CNT_W-1:0] ecy(input logic [3:0] c);
		return CNT_W'(ecy_tab[c]);
	endfunction
	localparam logic [7:0] ST = IDX_DEVICE_STATE;
	// main sequence
	initial begin
		void'($urandom(20921));
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		rdchk(IDX_TEST_SAMPLE_INTERVALS, 32'h0900);
		rdchk(IDX_SHUTDOWN_CAUSE, 32'h0);
		rdchk(ST, 32'h01);
		rdchk(8'h20, 32'h0);
		// code fields: all zero, all ones, then random, reserved kept at 1001
		for (int i = 0; i < 8; i++) begin
			v = {4'($urandom), RSVD_PATTERN, 8'($urandom)};
			if (i < 2) v = i ? 16'hf9ff : 16'h0900;
			wb(1, IDX_TEST_SAMPLE_INTERVALS, 32'(v), 4'h3);
			rdchk(IDX_TEST_SAMPLE_INTERVALS, 32'(v));
			`CHK({mc, rc, vc}, {v[15:12], v[7:4], v[3:0]})
			`CHK({mcy, rcy, vcy}, {ecy(v[15:12]), ecy(v[7:4]), ecy(v[3:0])})
		end
		// shutdown causes are sticky; only read back, never acted on
		for (int k = 0; k < 6; k++) begin
			pulse(k);
			exp_sd[cpos[k]] = 1'b1;
			rdchk(IDX_SHUTDOWN_CAUSE, 32'(exp_sd));
		end
		wb(1, IDX_SHUTDOWN_CAUSE, 32'h0, 4'hf);
		rdchk(IDX_SHUTDOWN_CAUSE, 32'hf3);
		summ <= 1;
		wb(1, ST, 32'h80, 4'h1);
		rdchk(ST, 32'h81);
		`CHK(fault_o, 1'b1)
		summ <= 0;
		chain <= 1;
		repeat (6) @(posedge clk_i);
		rdchk(ST, 32'h01);
		`CHK(fault_o, 1'b0)
		wb(1, IDX_DEVICE_CONFIG, 32'h100, 4'h3);
		rdchk(ST, 32'h61);
		`CHK(fault_o, 1'b1)
		chain <= 0;
		repeat (6) @(posedge clk_i);
		`CHK(fault_o, 1'b0)
		wb(1, ST, 32'h00, 4'h1);
		rdchk(ST, 32'h21);
		wb(1, ST, 32'h20, 4'h1);
		rdchk(ST, 32'h01);
		pulse(6);
		pulse(7);
		`CHK(fault_o, 1'b0)
		wb(1, ST, 32'h00, 4'h1);
		rdchk(ST, 32'h19);
		wb(1, ST, 32'h10, 4'h1);
		rdchk(ST, 32'h09);
		wb(1, ST, 32'h08, 4'h1);
		rdchk(ST, 32'h01);
		// new data: internal sampling ignored, write ignored, read clears
		s_int <= 1;
		pulse(8);
		rdchk(ST, 32'h01);
		s_int <= 0;
		pulse(8);
		wb(1, ST, 32'h02, 4'h1);
		rdchk(ST, 32'h03);
		pulse(9);
		rdchk(ST, 32'h01);
		// auto-monitor: refused with zero period, then start, then restart ignored
		wb(1, ST, 32'h04, 4'h1);
		`CHK(n_start, 0)
		wb(1, IDX_DEVICE_CONFIG, 32'h105, 4'h3);
		wb(1, ST, 32'h04, 4'h1);
		`CHK(n_start, 1)
		rdchk(ST, 32'h05);
		wb(1, ST, 32'h04, 4'h1);
		`CHK(n_start, 1)
		repeat (24) @(posedge clk_i);
		rdchk(ST, 32'h01);
		`CHK(skip, 1'b0)
		wb(1, ST, 32'h01, 4'h1);
		repeat (3) @(posedge clk_i);
		`CHK(skip, 1'b1)
		rdchk(ST, 32'h00);
		// second reset after the run has ended, then the module supply ends init
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		`CHK({ack_o, dat_o, skip}, 34'h0)
		rst_i <= 0;
		rdchk(ST, 32'h01);
		rdchk(IDX_TEST_SAMPLE_INTERVALS, 32'h0900);
		rdchk(IDX_SHUTDOWN_CAUSE, 32'h0);
		sok <= 1;
		repeat (2) @(posedge clk_i);
		rdchk(ST, 32'h00);
		end_sim();
	end
endmodule
